// ### dv/cmc_bus_node.sv
// partner model: one other node on the wired-and can bus line
module cmc_bus_node (
  input wire logic clk,
  input wire logic bus_transmit_pin,
  output logic bus_receive_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic node_drv;

  // ****************************************
  // bus line
  // ****************************************
  // dominant wins; a released line floats back to recessive like the real bus
  assign bus_receive_pin = bus_transmit_pin & node_drv;

  initial node_drv = 1'b1;

  // send bits msb first, bit_clks clocks each, then release the line
  // a long bit_clks gives a slow node, a short one a prompt node
  task automatic send(input logic [15:0] pat, input int nbits, input int bit_clks);
    for (int i = nbits - 1; i >= 0; i--) begin
      @(posedge clk);
      node_drv <= pat[i];
      repeat (bit_clks - 1) @(posedge clk);
    end
    @(posedge clk);
    node_drv <= 1'b1;
  endtask
endmodule

// ### dv/testbench.sv
// self-checking bench for the can mode controller
`include "cmc_defines.svh"
`define TB_CHECK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BT = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic core_tx_bit = 1'b1;
  logic core_tx_busy = 1'b0;
  logic core_tx_done = 1'b0;
  logic rx_msg_valid = 1'b0;
  logic [7:0] rd_data;
  logic rx_pin, tx_pin, core_enable, init_ack, low_power_ack, tx_request;
  logic [1:0] tx_mailbox_sel;
  logic [5:0] filter_active;
  logic [7:0] rv, t0, t1;
  int n_mismatch = 0;
  int check_count = 0;
  int n;

  // ****************************************
  // clock, design and bus partner
  // ****************************************
  // 200 MHz
  always #2.5 clk = ~clk;

  cmc_mode_ctrl dut_u (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .bus_receive_pin(rx_pin), .bus_transmit_pin(tx_pin),
    .core_tx_bit(core_tx_bit), .core_tx_busy(core_tx_busy),
    .core_tx_done(core_tx_done), .rx_msg_valid(rx_msg_valid),
    .core_enable(core_enable), .init_ack(init_ack), .low_power_ack(low_power_ack),
    .tx_request(tx_request), .tx_mailbox_sel(tx_mailbox_sel),
    .filter_active(filter_active)
  );

  cmc_bus_node node_u (.clk(clk), .bus_transmit_pin(tx_pin), .bus_receive_pin(rx_pin));

  // ****************************************
  // access tasks
  // ****************************************
  // settle one past the edge so flops have landed
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `TB_CHECK(nm, e, d)
  endtask

  task automatic pulse_done();
    @(posedge clk) core_tx_done <= 1'b1;
    @(posedge clk) core_tx_done <= 1'b0;
  endtask

  task automatic pulse_rx();
    @(posedge clk) rx_msg_valid <= 1'b1;
    @(posedge clk) rx_msg_valid <= 1'b0;
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // poll the two acks; a mode that never arrives ends the run
  task automatic wait_mode(input logic ia, input logic lp, input int lim, output int c);
    c = 0;
    while ({init_ack, low_power_ack} !== {ia, lp}) begin
      if (c >= lim) begin
        `TB_CHECK("mode wait", {ia, lp}, {init_ack, low_power_ack})
        finish_test();
      end
      tick(1);
      c++;
    end
  endtask

  // six recessive then two dominant bits, so a count that failed to restart
  // would finish early; n counts clocks from release to normal
  task automatic sync_exit(input logic [7:0] mcr);
    wr(`CMC_A_MCR, mcr);
    node_u.send(16'h00fc, 8, BT);
    wait_mode(1'b0, 1'b0, 200, n);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    `TB_CHECK("lp ack", 1'b1, low_power_ack)
    `TB_CHECK("init ack", 1'b0, init_ack)
    `TB_CHECK("core en", 1'b0, core_enable)
    `TB_CHECK("tx idle", 1'b1, tx_pin)
    rdc("mcr", `CMC_A_MCR, 8'h02);
    rdc("msr", `CMC_A_MSR, 8'h0a);
    rdc("btr", `CMC_A_BTR, 8'hc7);
    rdc("tpr", `CMC_A_TPR, `CMC_TPR_RST);
    rdc("unmapped", 5'h0c, 8'h00);
    // sleep to init, then no traffic and a recessive pin
    wr(`CMC_A_BTR, 8'h03);
    wr(`CMC_A_MCR, 8'h01);
    wait_mode(1'b1, 1'b0, 8, n);
    `TB_CHECK("init core", 1'b0, core_enable)
    @(posedge clk) core_tx_bit <= 1'b0;
    pulse_rx();
    tick(4);
    `TB_CHECK("init tx", 1'b1, tx_pin)
    rdc("init rfr", `CMC_A_RFR, 8'h00);
    // filter setup in init, paged window
    wr(`CMC_A_PSR, 8'h01);
    wr(5'h11, 8'h2a);
    wr(5'h12, 8'h15);
    wr(5'h10, 8'h05);
    rdc("flt mode", 5'h11, 8'h2a);
    rdc("flt scale", 5'h12, 8'h15);
    rdc("flt act", 5'h10, 8'h05);
    `TB_CHECK("flt port", 6'h05, filter_active)
    wr(`CMC_A_PSR, 8'h00);
    rdc("page0", 5'h10, 8'h00);
    @(posedge clk) core_tx_bit <= 1'b1;
    // leave init with the timer on
    sync_exit(8'h80);
    `TB_CHECK("sync wait", 1'b1, n >= 40 && n <= 70)
    `TB_CHECK("normal en", 1'b1, core_enable)
    rdc("msr norm", `CMC_A_MSR, 8'h08);
    // start of frame stamp lies between two timer reads
    rd(`CMC_A_TMRL, t0);
    node_u.send(16'h0000, 1, BT);
    tick(10);
    rd(`CMC_A_TMRL, t1);
    rd(5'h12, rv);
    `TB_CHECK("rx stamp", 1'b1, rv >= t0 && rv <= t1)
    `TB_CHECK("timer run", 1'b1, t1 > t0)
    // four messages into a three-deep fifo
    repeat (4) pulse_rx();
    rdc("fifo full", `CMC_A_RFR, 8'h13);
    wr(`CMC_A_RFR, 8'h20);
    rdc("fifo rel", `CMC_A_RFR, 8'h12);
    wr(`CMC_A_RFR, 8'h10);
    rdc("fifo ovr", `CMC_A_RFR, 8'h02);
    // mailbox choice, frozen during a frame
    wr(`CMC_A_TSR, 8'h06);
    tick(2);
    `TB_CHECK("tx req", 1'b1, tx_request)
    `TB_CHECK("mbx sel", 2'h1, tx_mailbox_sel)
    @(posedge clk) core_tx_busy <= 1'b1;
    wr(`CMC_A_TSR, 8'h01);
    tick(2);
    `TB_CHECK("mbx held", 2'h1, tx_mailbox_sel)
    // transmit stamp: start of frame while the core sends, once the bus is idle again
    tick(60);
    rd(`CMC_A_TMRL, t0);
    node_u.send(16'h0000, 1, BT);
    tick(10);
    rd(`CMC_A_TMRL, t1);
    rd(5'h10, rv);
    `TB_CHECK("tx stamp", 1'b1, rv >= t0 && rv <= t1)
    pulse_done();
    @(posedge clk) core_tx_busy <= 1'b0;
    tick(2);
    `TB_CHECK("mbx low", 2'h0, tx_mailbox_sel)
    rdc("tsr", `CMC_A_TSR, 8'h05);
    pulse_done();
    tick(2);
    `TB_CHECK("mbx two", 2'h2, tx_mailbox_sel)
    pulse_done();
    tick(2);
    `TB_CHECK("tx none", 1'b0, tx_request)
    // scale change outside init is refused
    wr(`CMC_A_PSR, 8'h01);
    wr(5'h12, 8'h3f);
    rdc("scale kept", 5'h12, 8'h15);
    @(posedge clk) core_tx_bit <= 1'b0;
    tick(2);
    `TB_CHECK("tx drive", 1'b0, tx_pin)
    // back to init: pin recessive, settings untouched
    wr(`CMC_A_MCR, 8'h81);
    wait_mode(1'b1, 1'b0, 4, n);
    tick(1);
    `TB_CHECK("reinit tx", 1'b1, tx_pin)
    rdc("btr kept", `CMC_A_BTR, 8'h03);
    rdc("psr kept", `CMC_A_PSR, 8'h01);
    rdc("flt kept", 5'h10, 8'h05);
    // prescale of one: the timer steps every second bit time, 82 clocks apart
    wr(`CMC_A_TPR, 8'h01);
    rd(`CMC_A_TMRL, t0);
    tick(80);
    rd(`CMC_A_TMRL, t1);
    `TB_CHECK("tmr scale", 1'b1, 8'(t1 - t0) >= 8'h0a && 8'(t1 - t0) <= 8'h0b)
    @(posedge clk) core_tx_bit <= 1'b1;
    sync_exit(8'h00);
    `TB_CHECK("resync", 1'b1, n >= 40 && n <= 70)
    // low power and its exit
    wr(`CMC_A_MCR, 8'h02);
    wait_mode(1'b0, 1'b1, 20, n);
    `TB_CHECK("sleep en", 1'b0, core_enable)
    sync_exit(8'h00);
    `TB_CHECK("wake wait", 1'b1, n >= 40 && n <= 70)
    `TB_CHECK("wake en", 1'b1, core_enable)
    finish_test();
  end
endmodule

// ### logic/cmc_defines.svh
// constants for the can mode controller: offsets, fields, reset values, timing
//
// Notes on behaviour
// - after reset the block sits in low-power mode with low_power_ack set
// - an acknowledge bit sets only once the requested mode is really entered
// - normal mode is exactly init_ack and low_power_ack both clear
// - entry to normal waits for 11 consecutive recessive bits on the receive pin
// - init_ack clears after recessive line and completed bus synchronisation, or at once on a move to low-power mode
// - in initialisation no frames move and the transmit pin stays recessive high
// - entering initialisation resets no configuration register
// - the protocol core handles 11-bit and 29-bit identifiers on its own
// - three transmit mailboxes with a scheduler choosing the first to send
// - receive fifo holds up to three messages behind one fixed address
// - six configurable acceptance filter banks
// - registers sit in 16-byte pages behind one window and a page select
// - bit rates up to 1 Mbit/s
// - 16-bit free-running timer with configurable resolution for timestamps
// - timestamp captured at start of frame for transmit and for receive
// - low-power exit ends when hardware clears low_power_ack after recessive line
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define CMC_A_MCR 5'h00
`define CMC_A_MSR 5'h01
`define CMC_A_TSR 5'h02
`define CMC_A_RFR 5'h03
`define CMC_A_TMRL 5'h04
`define CMC_A_TMRH 5'h05
`define CMC_A_PSR 5'h06
`define CMC_A_BTR 5'h07
`define CMC_A_TPR 5'h08
`define CMC_WIN_BIT 4
`define CMC_A_PG0 4'h0
`define CMC_A_PG1 4'h1
`define CMC_A_PG2 4'h2
`define CMC_A_PG3 4'h3

// ****************************************
// fields and reset values
// ****************************************
`define CMC_MCR_INIT 0
`define CMC_MCR_SLEEP 1
`define CMC_MCR_TMR_EN 7
`define CMC_MCR_MASK 8'h83
`define CMC_MCR_RST 8'h02
`define CMC_RFR_OVR 4
`define CMC_RFR_REL 5
`define CMC_FIFO_FULL 2'h3
`define CMC_NMBX 3
`define CMC_NFLT 6
`define CMC_TPR_RST 8'h00

// ****************************************
// timing
// ****************************************
`define CMC_CLK_NS 5
`define CMC_BIT_NS 1000
`define CMC_IDLE_BITS 4'hb

`endif

// ### logic/cmc_idle_det.sv
// receive pin synchroniser and bus-idle detector
`include "cmc_defines.svh"
module cmc_idle_det (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_pin,
  input wire logic bit_en,
  input wire logic restart,
  output logic rx_level,
  output logic idle
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      s1_q <= rx_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  // count recessive samples, saturating at the idle length
  assign cnt_d = restart ? 4'h0 :
                 !bit_en ? cnt_q :
                 !lvl_q ? 4'h0 :
                 (cnt_q == `CMC_IDLE_BITS) ? cnt_q : cnt_q + 4'h1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign rx_level = lvl_q;
  assign idle = (cnt_q == `CMC_IDLE_BITS);

  a_dominant_restart: assert property (@(posedge clk) disable iff (rst)
    bit_en && !restart && !lvl_q |=> cnt_q == 4'h0)
    else $error("idle count not restarted by dominant bit");
endmodule

// ### logic/cmc_mode_ctrl.sv
// can controller mode control, bus-idle sync, timer and register file
`include "cmc_defines.svh"
module cmc_mode_ctrl
  import cmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin,
  input wire logic core_tx_bit,
  input wire logic core_tx_busy,
  input wire logic core_tx_done,
  input wire logic rx_msg_valid,
  output logic core_enable,
  output logic init_ack,
  output logic low_power_ack,
  output logic tx_request,
  output logic [1:0] tx_mailbox_sel,
  output logic [5:0] filter_active
);

  // ****************************************
  // declarations
  // ****************************************
  localparam int BIT_CYC = `CMC_BIT_NS / `CMC_CLK_NS;

  cmc_mode_t mode_q;
  cmc_mode_t mode_d;
  logic [7:0] mcr_q;
  logic [7:0] btr_q;
  logic [7:0] brp_q;
  logic bit_en_q;
  logic [7:0] tpr_q;
  logic [7:0] tdiv_q;
  logic [15:0] timer_q;
  logic [15:0] txts_q;
  logic [15:0] rxts_q;
  logic [2:0] pend_q;
  logic [1:0] fifo_cnt_q;
  logic fifo_ovr_q;
  logic page_q;
  logic [5:0] fmode_q;
  logic [5:0] fscale_q;
  logic init_ack_d;
  logic lp_ack_d;
  logic rx_level;
  logic idle_w;
  logic [7:0] rd_mux;

  wire init_req = mcr_q[`CMC_MCR_INIT];
  wire sleep_req = mcr_q[`CMC_MCR_SLEEP];
  wire tmr_en = mcr_q[`CMC_MCR_TMR_EN];

  // ****************************************
  // register decode
  // ****************************************
  wire win = addr[`CMC_WIN_BIT];
  wire [3:0] woff = addr[3:0];
  wire wr_mcr = wr_en && (addr == `CMC_A_MCR);
  wire wr_tsr = wr_en && (addr == `CMC_A_TSR);
  wire wr_rfr = wr_en && (addr == `CMC_A_RFR);
  wire wr_psr = wr_en && (addr == `CMC_A_PSR);
  wire wr_btr = wr_en && (addr == `CMC_A_BTR);
  wire wr_tpr = wr_en && (addr == `CMC_A_TPR);
  // page 1 of the window holds the filter configuration
  wire wr_fp = wr_en && win && page_q;
  wire wr_filter_bank_active = wr_fp && (woff == `CMC_A_PG0);
  wire wr_fmode = wr_fp && (woff == `CMC_A_PG1);
  wire wr_fscale = wr_fp && (woff == `CMC_A_PG2);

  // ****************************************
  // bit-rate divider and idle detection
  // ****************************************
  // one enable pulse per bit time; reset value gives 1 Mbit/s
  wire brp_wrap = (brp_q >= btr_q); // a shorter bit time takes hold at once, no long wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      brp_q <= 8'h00;
      bit_en_q <= 1'b0;
    end else begin
      brp_q <= brp_wrap ? 8'h00 : brp_q + 8'h01;
      bit_en_q <= brp_wrap;
    end
  end

  // a fresh idle count starts on each entry to synchronisation
  wire sync_start = (mode_d == CMC_SYNC) && (mode_q != CMC_SYNC);

  cmc_idle_det u_idle (
    .clk(clk),
    .rst(rst),
    .rx_pin(bus_receive_pin),
    .bit_en(bit_en_q),
    .restart(sync_start),
    .rx_level(rx_level),
    .idle(idle_w)
  );

  // ****************************************
  // operating mode machine
  // ****************************************
  // sleep may be left for init only with the line recessive
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      CMC_SLEEP: begin
        if (!sleep_req) begin
          if (!init_req) begin
            mode_d = CMC_SYNC;
          end else if (rx_level) begin
            mode_d = CMC_INIT;
          end
        end
      end
      CMC_INIT: begin
        if (!init_req) begin
          mode_d = sleep_req ? CMC_SLEEP : CMC_SYNC;
        end
      end
      CMC_SYNC: begin
        if (init_req) begin
          mode_d = CMC_INIT;
        end else if (sleep_req) begin
          mode_d = CMC_SLEEP;
        end else if (idle_w && rx_level) begin
          mode_d = CMC_NORMAL;
        end
      end
      CMC_NORMAL: begin
        if (init_req) begin
          mode_d = CMC_INIT;
        end else if (sleep_req) begin
          mode_d = CMC_SLEEP;
        end
      end
      default: begin
        mode_d = CMC_SLEEP;
      end
    endcase
  end

  // acks follow the mode actually entered; held while synchronising
  always_comb begin
    init_ack_d = init_ack;
    lp_ack_d = low_power_ack;
    case (mode_d)
      CMC_INIT: begin
        init_ack_d = 1'b1;
        lp_ack_d = 1'b0;
      end
      CMC_SLEEP: begin
        init_ack_d = 1'b0;
        lp_ack_d = 1'b1;
      end
      CMC_NORMAL: begin
        init_ack_d = 1'b0;
        lp_ack_d = 1'b0;
      end
      default: begin
        init_ack_d = init_ack;
        lp_ack_d = low_power_ack;
      end
    endcase
  end

  // transmit pin forced recessive outside normal mode
  wire in_normal_d = (mode_d == CMC_NORMAL);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= CMC_SLEEP;
      init_ack <= 1'b0;
      low_power_ack <= 1'b1;
      core_enable <= 1'b0;
      bus_transmit_pin <= 1'b1;
    end else begin
      mode_q <= mode_d;
      init_ack <= init_ack_d;
      low_power_ack <= lp_ack_d;
      core_enable <= in_normal_d;
      bus_transmit_pin <= in_normal_d ? core_tx_bit : 1'b1;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // mode changes never touch these, only reset and writes do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mcr_q <= `CMC_MCR_RST;
      btr_q <= 8'(BIT_CYC - 1);
      tpr_q <= `CMC_TPR_RST;
      page_q <= 1'b0;
    end else begin
      if (wr_mcr) mcr_q <= wdata & `CMC_MCR_MASK;
      if (wr_btr) btr_q <= wdata;
      if (wr_tpr) tpr_q <= wdata;
      if (wr_psr) page_q <= wdata[0];
    end
  end

  // filter banks; scale and mode only take effect in init
  wire cfg_ok = (mode_q == CMC_INIT);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_active <= 6'h00;
      fmode_q <= 6'h00;
      fscale_q <= 6'h00;
    end else begin
      if (wr_filter_bank_active) filter_active <= wdata[5:0];
      if (wr_fmode && cfg_ok) fmode_q <= wdata[5:0];
      if (wr_fscale && cfg_ok) fscale_q <= wdata[5:0];
    end
  end

  // ****************************************
  // transmit mailboxes and scheduler
  // ****************************************
  // a new request wins over a completion in the same cycle
  wire [2:0] pend_set = wr_tsr ? wdata[2:0] : 3'h0;
  wire [2:0] pend_clr = core_tx_done ? (3'h1 << tx_mailbox_sel) : 3'h0;
  wire [2:0] pend_d = (pend_q & ~pend_clr) | pend_set;
  // equal priority: lowest mailbox number goes first
  wire [1:0] sel_d = pend_q[0] ? 2'h0 : pend_q[1] ? 2'h1 : 2'h2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 3'h0;
      tx_mailbox_sel <= 2'h0;
      tx_request <= 1'b0;
    end else begin
      pend_q <= pend_d;
      // choice frozen while a frame is on the wire
      if (!core_tx_busy) tx_mailbox_sel <= sel_d;
      tx_request <= (|pend_q) && in_normal_d;
    end
  end

  // ****************************************
  // receive fifo bookkeeping
  // ****************************************
  wire fifo_full = (fifo_cnt_q == `CMC_FIFO_FULL);
  wire rx_in = rx_msg_valid && core_enable;
  wire rel_w = wr_rfr && wdata[`CMC_RFR_REL] && (fifo_cnt_q != 2'h0);
  wire push = rx_in && !fifo_full;
  wire ovr_clr = wr_rfr && wdata[`CMC_RFR_OVR];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_cnt_q <= 2'h0;
      fifo_ovr_q <= 1'b0;
    end else begin
      if (push && !rel_w) fifo_cnt_q <= fifo_cnt_q + 2'h1;
      if (rel_w && !push) fifo_cnt_q <= fifo_cnt_q - 2'h1;
      // overrun set wins over a clear in the same cycle
      fifo_ovr_q <= (rx_in && fifo_full) || (fifo_ovr_q && !ovr_clr);
    end
  end

  // ****************************************
  // timer and timestamps
  // ****************************************
  // resolution is a prescale of bit times
  wire tmr_tick = bit_en_q && tmr_en && (tdiv_q == tpr_q);
  // start of frame: first dominant bit after the bus was idle
  wire sof_w = bit_en_q && core_enable && idle_w && !rx_level;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdiv_q <= 8'h00;
      timer_q <= 16'h0000;
      txts_q <= 16'h0000;
      rxts_q <= 16'h0000;
    end else begin
      if (bit_en_q && tmr_en) tdiv_q <= (tdiv_q == tpr_q) ? 8'h00 : tdiv_q + 8'h01;
      if (tmr_tick) timer_q <= timer_q + 16'h0001;
      if (sof_w && core_tx_busy) txts_q <= timer_q;
      if (sof_w && !core_tx_busy) rxts_q <= timer_q;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // paged window: page 0 timestamps, page 1 filter setup
  wire [7:0] pg0_mux = (woff == `CMC_A_PG0) ? txts_q[7:0] :
                       (woff == `CMC_A_PG1) ? txts_q[15:8] :
                       (woff == `CMC_A_PG2) ? rxts_q[7:0] :
                       (woff == `CMC_A_PG3) ? rxts_q[15:8] : 8'h00;
  wire [7:0] pg1_mux = (woff == `CMC_A_PG0) ? {2'h0, filter_active} :
                       (woff == `CMC_A_PG1) ? {2'h0, fmode_q} :
                       (woff == `CMC_A_PG2) ? {2'h0, fscale_q} : 8'h00;
  wire [7:0] msr_v = {4'h0, rx_level, 1'b0, low_power_ack, init_ack};
  assign rd_mux = win ? (page_q ? pg1_mux : pg0_mux) :
                  (addr == `CMC_A_MCR) ? mcr_q :
                  (addr == `CMC_A_MSR) ? msr_v :
                  (addr == `CMC_A_TSR) ? {2'h0, tx_mailbox_sel, 1'b0, pend_q} :
                  (addr == `CMC_A_RFR) ? {3'h0, fifo_ovr_q, 2'h0, fifo_cnt_q} :
                  (addr == `CMC_A_TMRL) ? timer_q[7:0] :
                  (addr == `CMC_A_TMRH) ? timer_q[15:8] :
                  (addr == `CMC_A_PSR) ? {7'h00, page_q} :
                  (addr == `CMC_A_BTR) ? btr_q :
                  (addr == `CMC_A_TPR) ? tpr_q : 8'h00;

  // data valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_en ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_low_power: assert property (
    $fell(rst) |-> low_power_ack && !init_ack && bus_transmit_pin)
    else $error("not in low-power mode after reset");

  a_init_ack_cause: assert property (
    $rose(init_ack) |-> $past(init_req))
    else $error("init_ack set without a request");

  a_normal_acks: assert property (
    core_enable == (!init_ack && !low_power_ack))
    else $error("normal mode and acks disagree");

  a_sync_idle: assert property (
    $rose(core_enable) |-> $past(idle_w && rx_level))
    else $error("normal entered without bus idle");

  a_init_exit: assert property (
    $fell(init_ack) && !low_power_ack |-> $past(idle_w && rx_level))
    else $error("init left before synchronisation");

  a_init_tx_high: assert property (
    init_ack |-> bus_transmit_pin && !tx_request)
    else $error("transmit active in init mode");

  a_lp_exit: assert property (
    $fell(low_power_ack) |-> $past(rx_level))
    else $error("low-power left with dominant line");

  a_fifo_overrun: assert property (
    rx_in && fifo_full && !rel_w |=> fifo_ovr_q && fifo_cnt_q == 2'h3)
    else $error("full fifo not flagged");

  a_sched_first: assert property (
    !core_tx_busy && pend_q[0] |=> tx_mailbox_sel == 2'h0)
    else $error("mailbox 0 not chosen first");

  a_timer_step: assert property (
    tmr_tick |=> timer_q == $past(timer_q) + 16'h0001)
    else $error("timer did not advance");

  a_tx_stamp: assert property (
    sof_w && core_tx_busy |=> txts_q == $past(timer_q))
    else $error("transmit timestamp not captured");

  c_enter_normal: cover property ($rose(core_enable));
  c_fifo_full: cover property (fifo_full && rx_in);
  c_rx_sof: cover property (sof_w && !core_tx_busy);
endmodule

// ### logic/cmc_pkg.sv
// types shared by the can mode controller
package cmc_pkg;
  typedef enum logic [1:0] {
    CMC_SLEEP,
    CMC_INIT,
    CMC_SYNC,
    CMC_NORMAL
  } cmc_mode_t;
endpackage
